// ### tb/caf_bus_node.sv
`timescale 1ns/1ns
// Stands in for the other nodes on the bus: delivers received frames and
// reports how each transmit attempt of the device ended.
module caf_bus_node (
	input wire logic ref_clk,
	output logic rx_valid,
	output logic [28:0] rx_id,
	output logic rx_ext,
	output logic rx_rtr,
	output logic [7:0] rx_data0,
	output logic [7:0] rx_data1,
	output logic tx_end,
	output logic tx_ok,
	output logic [28:0] tx_id,
	output logic tx_ext,
	output logic tx_rtr,
	output logic [7:0] tx_data0,
	output logic [7:0] tx_data1
);
	initial begin
		{rx_valid, tx_end, tx_ok} = 3'h0;
		{rx_id, rx_ext, rx_rtr, rx_data0, rx_data1} = '0;
		{tx_id, tx_ext, tx_rtr, tx_data0, tx_data1} = '0;
	end
	////////////////////////////////////////////////////////////////////
	// Fields flip after the strobe so stale values are never taken as held
	task automatic frame(input logic [28:0] id, input logic [1:0] er,
			input logic [15:0] d);
		{rx_id, rx_ext, rx_rtr, rx_data0, rx_data1} = {id, er, d};
		rx_valid = 1'b1;
		@(posedge ref_clk);
		#1;
		rx_valid = 1'b0;
		{rx_id, rx_ext, rx_rtr, rx_data0, rx_data1} = ~{id, er, d};
		// One idle edge so the next frame never re-raises the strobe at once
		@(posedge ref_clk);
		#1;
	endtask : frame
	// Ack low: no other node acknowledged the attempt
	task automatic attempt(input logic ack, input logic [28:0] id,
			input logic [1:0] er, input logic [15:0] d);
		{tx_id, tx_ext, tx_rtr, tx_data0, tx_data1} = {id, er, d};
		tx_ok = ack;
		tx_end = 1'b1;
		@(posedge ref_clk);
		#1;
		{tx_end, tx_ok} = 2'b00;
		{tx_id, tx_ext, tx_rtr, tx_data0, tx_data1} = ~{id, er, d};
	endtask : attempt
endmodule : caf_bus_node

// ### tb/caf_filter_tb_top.sv
`timescale 1ns/1ns
module caf_filter_tb_top;
	import caf_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n, cfg_load, self_echo_enable, no_retry_transmit;
	caf_mode_t accept_filter_mode;
	logic [31:0] accept_compare_value, accept_ignore_mask;
	logic [10:0] legacy_short_id_mask, legacy_short_id_compare;
	logic [28:0] legacy_long_id_mask, legacy_long_id_compare;
	logic [7:0] rx_queue_depth, rx_notify_threshold;
	logic rd_req, overflow_clear;
	logic rx_valid, rx_ext, rx_rtr, tx_end, tx_ok, tx_ext, tx_rtr;
	logic [28:0] rx_id, tx_id, rd_id;
	logic [7:0] rx_data0, rx_data1, tx_data0, tx_data1;
	logic rd_valid, rd_ext, rd_rtr, multi_avail, rx_overflow;
	logic tx_retry, tx_abandon;
	logic [7:0] rd_data0, rd_data1, rx_count;
	int n_fail = 0;
	int checked = 0;
	always #4 ref_clk = ~ref_clk;
	caf_bus_node node (.ref_clk, .rx_valid, .rx_id, .rx_ext, .rx_rtr,
		.rx_data0, .rx_data1, .tx_end, .tx_ok, .tx_id, .tx_ext, .tx_rtr,
		.tx_data0, .tx_data1);
	// Small queue ceiling keeps every queue within the 12 reads of drain
	caf_filter #(.MAX_DEPTH(8)) dut (.ref_clk, .arst_n, .cfg_load,
		.accept_filter_mode, .accept_compare_value, .accept_ignore_mask,
		.legacy_short_id_mask, .legacy_short_id_compare,
		.legacy_long_id_mask, .legacy_long_id_compare, .self_echo_enable,
		.no_retry_transmit, .rx_queue_depth, .rx_notify_threshold,
		.rx_valid, .rx_id, .rx_ext, .rx_rtr, .rx_data0, .rx_data1, .tx_end,
		.tx_ok, .tx_id, .tx_ext, .tx_rtr, .tx_data0, .tx_data1, .rd_req,
		.overflow_clear, .rd_valid, .rd_id, .rd_ext, .rd_rtr, .rd_data0,
		.rd_data1, .rx_count, .multi_avail, .rx_overflow, .tx_retry,
		.tx_abandon);
	////////////////////////////////////////////////////////////////////
	task automatic conclude;
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask : tick
	task automatic cfg(input caf_mode_t m, input logic [31:0] c, k,
			input logic echo, nr, input logic [7:0] dep);
		accept_filter_mode = m;
		accept_compare_value = c;
		accept_ignore_mask = k;
		self_echo_enable = echo;
		no_retry_transmit = nr;
		rx_queue_depth = dep;
		cfg_load = 1'b1;
		tick();
		cfg_load = 1'b0;
	endtask : cfg
	task automatic rxc(input logic [28:0] id, input logic [1:0] er,
			input logic [15:0] d, input logic [7:0] n);
		node.frame(id, er, d);
		chk(32'(rx_count), 32'(n));
	endtask : rxc
	task automatic pop(input logic [28:0] id, input logic [15:0] d);
		rd_req = 1'b1;
		tick();
		rd_req = 1'b0;
		chk(32'(rd_valid), 32'h0000_0001);
		chk({3'h0, rd_id}, {3'h0, id});
		chk(32'({rd_data0, rd_data1}), 32'(d));
		chk(32'({rd_ext, rd_rtr}), 32'h0000_0000);
		tick();
	endtask : pop
	// Bounded: a queue that never empties ends the run
	task automatic drain;
		rd_req = 1'b1;
		for (int i = 0; i < 12 && rx_count != 8'h00; i++)
			tick();
		rd_req = 1'b0;
		tick();
		if (rx_count !== 8'h00) begin
			chk(32'(rx_count), 32'h0000_0000);
			conclude();
		end
	endtask : drain
	////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk(32'({multi_avail, rx_overflow, rd_valid}), 32'h0000_0000);
		node.attempt(1'b1, 29'h0055, 2'b00, 16'h0000);
		tick();
		chk(32'(rx_count), 32'h0000_0000);
		rxc(29'h07FF, 2'b01, 16'hFFFF, 8'h01);
		rxc(29'h1FFF_FFFF, 2'b10, 16'h1234, 8'h02);
		drain();
	endtask : t_reset
	task automatic t_modes;
		cfg(CAF_SINGLE_STD, 32'h0246_A500, 32'h0000_00FF, 1'b0, 1'b0, 8'h64);
		rxc(29'h0123, 2'b00, 16'hA577, 8'h01);
		rxc(29'h0123, 2'b00, 16'hA477, 8'h01);
		rxc(29'h0122, 2'b00, 16'hA577, 8'h01);
		rxc(29'h0123, 2'b01, 16'hA577, 8'h01);
		rxc(29'h0123, 2'b00, 16'hA5EE, 8'h02);
		pop(29'h0123, 16'hA577);
		pop(29'h0123, 16'hA5EE);
		cfg(CAF_SINGLE_EXT, {2'b00, 29'h0ABC_DEF1, 1'b1}, 32'h0,
			1'b0, 1'b0, 8'h64);
		rxc(29'h0ABC_DEF1, 2'b11, 16'h0000, 8'h01);
		rxc(29'h0ABC_DEF1, 2'b10, 16'h0000, 8'h01);
		rxc(29'h0ABC_DEF0, 2'b11, 16'h0000, 8'h01);
		drain();
		cfg(CAF_DUAL_STD, {11'h0AA, 1'b0, 8'h5C, 11'h155, 1'b1},
			32'h0000_0000, 1'b0, 1'b0, 8'h64);
		rxc(29'h00AA, 2'b00, 16'h5C00, 8'h01);
		rxc(29'h00AA, 2'b00, 16'h5D00, 8'h01);
		rxc(29'h0155, 2'b01, 16'h7700, 8'h02);
		rxc(29'h0155, 2'b00, 16'h7700, 8'h02);
		drain();
		cfg(CAF_DUAL_EXT, {16'h1234, 16'hBEEF}, 32'h0000_0000, 1'b0, 1'b0,
			8'h64);
		rxc({16'h1234, 13'h1FFF}, 2'b10, 16'h0000, 8'h01);
		rxc({16'hBEEF, 13'h0005}, 2'b11, 16'h0000, 8'h02);
		rxc({16'h1235, 13'h0000}, 2'b10, 16'h0000, 8'h02);
		drain();
	endtask : t_modes
	task automatic t_legacy;
		legacy_short_id_mask = 11'h700;
		legacy_short_id_compare = 11'h300;
		cfg(CAF_SINGLE_STD, 32'h0000_0000, 32'h0FFF_FFFF, 1'b0, 1'b0, 8'h64);
		rxc(29'h03AB, 2'b00, 16'h0000, 8'h01);
		rxc(29'h04AB, 2'b00, 16'h0000, 8'h01);
		drain();
		{legacy_short_id_mask, legacy_short_id_compare} = 22'h0;
	endtask : t_legacy
	task automatic t_echo;
		cfg(CAF_SINGLE_STD, 32'h0246_0000, 32'h0001_FFFF, 1'b1, 1'b0, 8'h64);
		node.attempt(1'b1, 29'h0123, 2'b00, 16'h4242);
		tick();
		chk(32'(rx_count), 32'h0000_0001);
		node.attempt(1'b0, 29'h0123, 2'b00, 16'h4343);
		tick();
		chk(32'(rx_count), 32'h0000_0001);
		node.attempt(1'b1, 29'h0124, 2'b00, 16'h4444);
		tick();
		chk(32'(rx_count), 32'h0000_0001);
		pop(29'h0123, 16'h4242);
		drain();
	endtask : t_echo
	task automatic t_retry;
		cfg(CAF_SINGLE_STD, 32'h0000_0000, 32'h0FFF_FFFF, 1'b0, 1'b0, 8'h64);
		node.attempt(1'b0, 29'h0010, 2'b00, 16'h0000);
		chk(32'({tx_retry, tx_abandon}), 32'h0000_0002);
		tick();
		chk(32'({tx_retry, tx_abandon}), 32'h0000_0000);
		cfg(CAF_SINGLE_STD, 32'h0000_0000, 32'h0FFF_FFFF, 1'b0, 1'b1, 8'h64);
		node.attempt(1'b0, 29'h0010, 2'b00, 16'h0000);
		chk(32'({tx_retry, tx_abandon}), 32'h0000_0001);
		tick();
		node.attempt(1'b1, 29'h0010, 2'b00, 16'h0000);
		chk(32'({tx_retry, tx_abandon}), 32'h0000_0000);
		drain();
	endtask : t_retry
	task automatic t_depth;
		cfg(CAF_SINGLE_STD, 32'h0000_0000, 32'h0FFF_FFFF, 1'b0, 1'b0, 8'h04);
		for (int i = 1; i <= 5; i++) begin
			rxc(29'(i), 2'b00, 16'h0000, 8'(i > 4 ? 4 : i));
			tick();
			chk(32'(multi_avail), 32'(i >= 2));
		end
		chk(32'(rx_overflow), 32'h0000_0001);
		rx_notify_threshold = 8'h05;
		overflow_clear = 1'b1;
		cfg(CAF_SINGLE_STD, 32'h0000_0000, 32'h0FFF_FFFF, 1'b0, 1'b0, 8'h04);
		overflow_clear = 1'b0;
		tick();
		chk(32'({multi_avail, rx_overflow}), 32'h0000_0000);
		pop(29'h0001, 16'h0000);
		rx_notify_threshold = 8'h00;
		drain();
	endtask : t_depth
	////////////////////////////////////////////////////////////////////
	initial begin
		{arst_n, cfg_load, rd_req, overflow_clear} = 4'h0;
		{self_echo_enable, no_retry_transmit} = 2'b00;
		accept_filter_mode = CAF_SINGLE_STD;
		accept_compare_value = 32'h0000_0000;
		accept_ignore_mask = 32'h0FFF_FFFF;
		{legacy_short_id_mask, legacy_short_id_compare} = 22'h0;
		{legacy_long_id_mask, legacy_long_id_compare} = 58'h0;
		rx_queue_depth = 8'h64;
		rx_notify_threshold = 8'h00;
		repeat (16) @(posedge ref_clk);
		#1;
		arst_n = 1'b1;
		tick();
		t_reset();
		t_modes();
		t_legacy();
		t_echo();
		t_retry();
		t_depth();
		conclude();
	end
endmodule : caf_filter_tb_top

// ### verilog/caf_filter.sv
`timescale 1ns/1ns
// Function
// (R1) Receive queue depth configurable, 100 recommended
// (R2) Notify threshold programmable, default half depth
// (R3) Acknowledged transmits echo into receive path
// (R4) Unacknowledged transmits are never echoed
// (R5) Self echo disabled after reset
// (R6) Filter precedes every receive consumer
// (R7) Reset filter mode is single standard
// (R8) Dual extended: two upper-16 filters, either
// (R9) Dual standard: id rtr data0, id rtr
// (R10) Dual modes discard only if neither matches
// (R11) Single extended: 29 id bits plus rtr
// (R12) Single standard: id, rtr, two data bytes
// (R13) Software writes zero to reserved bits
// (R14) Mask clear compares, mask set ignores
// (R15) Compare resets zero, mask resets FFFFFFF
// (R16) Legacy masks use opposite polarity
// (R17) Legacy mask set bit compares identifier
// (R18) Host should zero legacy masks, compares
// (R19) Retry failed transmit unless single shot
// (R20) Single shot: one attempt, no retry
// (R21) Field placement in mask words is defined
module caf_filter #(
	parameter int unsigned MAX_DEPTH = caf_pkg::CAF_MAX_DEPTH
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic cfg_load,
	input wire caf_pkg::caf_mode_t accept_filter_mode,
	input wire logic [31:0] accept_compare_value,
	input wire logic [31:0] accept_ignore_mask,
	input wire logic [10:0] legacy_short_id_mask,
	input wire logic [10:0] legacy_short_id_compare,
	input wire logic [28:0] legacy_long_id_mask,
	input wire logic [28:0] legacy_long_id_compare,
	input wire logic self_echo_enable,
	input wire logic no_retry_transmit,
	input wire logic [7:0] rx_queue_depth,
	input wire logic [7:0] rx_notify_threshold,
	input wire logic rx_valid,
	input wire logic [28:0] rx_id,
	input wire logic rx_ext,
	input wire logic rx_rtr,
	input wire logic [7:0] rx_data0,
	input wire logic [7:0] rx_data1,
	input wire logic tx_end,
	input wire logic tx_ok,
	input wire logic [28:0] tx_id,
	input wire logic tx_ext,
	input wire logic tx_rtr,
	input wire logic [7:0] tx_data0,
	input wire logic [7:0] tx_data1,
	input wire logic rd_req,
	input wire logic overflow_clear,
	output logic rd_valid,
	output logic [28:0] rd_id,
	output logic rd_ext,
	output logic rd_rtr,
	output logic [7:0] rd_data0,
	output logic [7:0] rd_data1,
	output logic [7:0] rx_count,
	output logic multi_avail,
	output logic rx_overflow,
	output logic tx_retry,
	output logic tx_abandon
);
	import caf_pkg::*;

	localparam int unsigned PTR_W = $clog2(MAX_DEPTH);
	localparam int unsigned ENT_W = CAF_ID_W + 18;
	localparam logic [7:0] DEPTH_CAP = 8'(MAX_DEPTH);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(MAX_DEPTH - 1);

	////////////////////////////////////////////////////////////////////
	// Configuration, held until the next load strobe
	caf_mode_t cur_mode;
	logic [31:0] cur_compare;
	logic [31:0] cur_mask;
	logic [10:0] cur_lsm;
	logic [10:0] cur_lsc;
	logic [28:0] cur_llm;
	logic [28:0] cur_llc;
	logic cur_echo;
	logic cur_no_retry;
	logic [7:0] cur_depth;
	logic [7:0] cur_thresh;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur_mode <= CAF_MODE_RESET; // R7
			cur_compare <= CAF_COMPARE_RESET; // R15
			cur_mask <= CAF_MASK_RESET; // R15
			cur_lsm <= CAF_LEG_SHORT_RESET;
			cur_lsc <= CAF_LEG_SHORT_RESET;
			cur_llm <= CAF_LEG_LONG_RESET;
			cur_llc <= CAF_LEG_LONG_RESET;
			cur_echo <= CAF_ECHO_RESET; // R5
			cur_no_retry <= CAF_NO_RETRY_RESET; // R19
			cur_depth <= CAF_DEPTH_RESET; // R1
			cur_thresh <= CAF_THRESH_RESET; // R2
		end else if (cfg_load) begin
			cur_mode <= accept_filter_mode;
			cur_compare <= accept_compare_value;
			cur_mask <= accept_ignore_mask;
			cur_lsm <= legacy_short_id_mask;
			cur_lsc <= legacy_short_id_compare;
			cur_llm <= legacy_long_id_mask;
			cur_llc <= legacy_long_id_compare;
			cur_echo <= self_echo_enable;
			cur_no_retry <= no_retry_transmit;
			cur_depth <= rx_queue_depth;
			cur_thresh <= rx_notify_threshold;
		end
	end

	logic [7:0] depth_eff;
	logic [7:0] thresh_eff;
	assign depth_eff = (cur_depth > DEPTH_CAP) ? DEPTH_CAP : cur_depth; // R1
	// Zero threshold selects half of the queue depth
	assign thresh_eff = (cur_thresh == 8'h00) ? (depth_eff >> 1) :
		cur_thresh; // R2

	////////////////////////////////////////////////////////////////////
	// Self echo; held for as long as rx_valid stays high, so a live receive goes first
	logic echo_pending;
	logic [ENT_W-1:0] echo_frame;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			echo_pending <= 1'b0;
			echo_frame <= '0;
		end else if (tx_end && tx_ok && cur_echo) begin // R3 R4 R5
			echo_pending <= 1'b1;
			echo_frame <= {tx_id, tx_ext, tx_rtr, tx_data0, tx_data1};
		end else if (!rx_valid) begin
			echo_pending <= 1'b0;
		end
	end

	logic cand_valid;
	logic cand_echo;
	logic [ENT_W-1:0] cand;
	logic [28:0] c_id;
	logic c_ext;
	logic c_rtr;
	logic [7:0] c_d0;
	logic [7:0] c_d1;

	assign cand_valid = rx_valid || echo_pending;
	assign cand_echo = !rx_valid && echo_pending;
	// An echo enters the same path as a received frame
	assign cand = rx_valid ? {rx_id, rx_ext, rx_rtr, rx_data0, rx_data1} :
		echo_frame; // R3
	assign {c_id, c_ext, c_rtr, c_d0, c_d1} = cand;

	////////////////////////////////////////////////////////////////////
	// Acceptance filter; reserved bits are never compared
	function automatic logic fmatch(input logic [31:0] f,
		input logic [31:0] c, input logic [31:0] m);
		fmatch = &(~(f ^ c) | m); // R14
	endfunction : fmatch

	logic [31:0] f_ss;
	logic [31:0] f_se;
	logic [31:0] f_ds;
	logic [31:0] f_de;
	logic [31:0] use_ss;
	logic [31:0] use_se;
	logic [31:0] use_ds1;
	logic [31:0] use_ds2;
	logic [31:0] use_de1;
	logic [31:0] use_de2;
	logic ds1_hit;
	logic ds2_hit;
	logic de1_hit;
	logic de2_hit;
	logic mode_hit;
	logic legacy_hit;
	logic accept;

	always_comb begin
		f_ss = '0;
		f_ss[CAF_SS_ID_LSB +: CAF_SID_W] = c_id[10:0];
		f_ss[CAF_SS_RTR] = c_rtr;
		f_ss[CAF_SS_D0_LSB +: 8] = c_d0;
		f_ss[CAF_SS_D1_LSB +: 8] = c_d1; // R12 R21
		use_ss = 32'h0FFF_FFFF;
		f_se = '0;
		f_se[CAF_SE_ID_LSB +: CAF_ID_W] = c_id;
		f_se[CAF_SE_RTR] = c_rtr; // R11
		use_se = 32'h3FFF_FFFF;
		f_ds = '0;
		f_ds[CAF_DS1_ID_LSB +: CAF_SID_W] = c_id[10:0];
		f_ds[CAF_DS1_RTR] = c_rtr;
		f_ds[CAF_DS1_D0_LSB +: 8] = c_d0;
		f_ds[CAF_DS2_ID_LSB +: CAF_SID_W] = c_id[10:0];
		f_ds[CAF_DS2_RTR] = c_rtr; // R9
		use_ds1 = 32'hFFFF_F000;
		use_ds2 = 32'h0000_0FFF;
		f_de = {c_id[CAF_DE_ID_LSB +: 16], c_id[CAF_DE_ID_LSB +: 16]}; // R8
		use_de1 = 32'hFFFF_0000;
		use_de2 = 32'h0000_FFFF;
	end

	// Bits outside a filter's fields count as don't-care
	assign ds1_hit = fmatch(f_ds, cur_compare, cur_mask | ~use_ds1);
	assign ds2_hit = fmatch(f_ds, cur_compare, cur_mask | ~use_ds2);
	assign de1_hit = fmatch(f_de, cur_compare, cur_mask | ~use_de1);
	assign de2_hit = fmatch(f_de, cur_compare, cur_mask | ~use_de2);

	// Frames of the other identifier format bypass the mode filter
	always_comb begin
		mode_hit = 1'b1;
		unique case (cur_mode)
			CAF_SINGLE_STD: if (!c_ext) begin
				mode_hit = fmatch(f_ss, cur_compare, cur_mask | ~use_ss);
			end
			CAF_SINGLE_EXT: if (c_ext) begin
				mode_hit = fmatch(f_se, cur_compare, cur_mask | ~use_se);
			end
			CAF_DUAL_STD: if (!c_ext) begin
				mode_hit = ds1_hit || ds2_hit; // R9 R10
			end
			CAF_DUAL_EXT: if (c_ext) begin
				mode_hit = de1_hit || de2_hit; // R8 R10
			end
		endcase
	end

	// Legacy masks: a set bit compares, the reverse of the mode mask
	assign legacy_hit = c_ext ? ~|((c_id ^ cur_llc) & cur_llm) :
		~|((c_id[10:0] ^ cur_lsc) & cur_lsm); // R16 R17
	assign accept = mode_hit && legacy_hit; // R6

	////////////////////////////////////////////////////////////////////
	// Receive queue; the only consumer, so a reject reaches nothing
	logic [ENT_W-1:0] mem [MAX_DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic do_wr;
	logic do_rd;
	logic full;

	assign full = (rx_count >= depth_eff); // R1
	assign do_wr = cand_valid && accept && !full; // R6
	assign do_rd = rd_req && (rx_count != 8'h00);

	always_ff @(posedge ref_clk) begin
		if (do_wr) begin
			mem[wr_ptr] <= cand;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			rx_count <= 8'h00;
		end else begin
			if (do_wr) begin
				wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
			end
			rx_count <= rx_count + 8'(do_wr) - 8'(do_rd);
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_valid <= 1'b0;
			{rd_id, rd_ext, rd_rtr, rd_data0, rd_data1} <= '0;
		end else begin
			rd_valid <= do_rd;
			if (do_rd) begin
				{rd_id, rd_ext, rd_rtr, rd_data0, rd_data1} <= mem[rd_ptr];
			end
		end
	end

	// Lags the count by one cycle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			multi_avail <= 1'b0;
		end else begin
			multi_avail <= (rx_count != 8'h00) &&
				(rx_count >= thresh_eff); // R2
		end
	end

	// A new overflow in the clearing cycle keeps the flag set
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_overflow <= 1'b0;
		end else if (cand_valid && accept && full) begin
			rx_overflow <= 1'b1;
		end else if (overflow_clear) begin
			rx_overflow <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Transmit retry decision
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_retry <= 1'b0;
			tx_abandon <= 1'b0;
		end else begin
			tx_retry <= tx_end && !tx_ok && !cur_no_retry; // R19
			tx_abandon <= tx_end && !tx_ok && cur_no_retry; // R20
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	AST_FULL_HOLDS: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(full && !do_rd) |=> (rx_count == $past(rx_count))) // R1
		else $error("queue grew while full");
	AST_THRESH: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(cur_thresh == 8'h00 && rx_count == (depth_eff >> 1) &&
		rx_count != 8'h00 && !cfg_load) |=> multi_avail) // R2
		else $error("default threshold not at half depth");
	AST_ECHO_IN: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(tx_end && tx_ok && cur_echo && !echo_pending) |=>
		##[0:8] cand_echo) // R3
		else $error("acknowledged transmit not echoed");
	AST_NO_NACK_ECHO: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		(tx_end && !tx_ok && !echo_pending) |=> !echo_pending) // R4
		else $error("unacknowledged transmit echoed");
	AST_ECHO_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(!cur_echo && !echo_pending) |=> !echo_pending) // R5
		else $error("echo while self echo disabled");
	AST_REJECT: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(cand_valid && !accept && !do_rd) |=>
		(rx_count == $past(rx_count) && wr_ptr == $past(wr_ptr))) // R6
		else $error("rejected frame stored");
	AST_DUAL_MISS: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(cand_valid && cur_mode == CAF_DUAL_STD && !c_ext &&
		!ds1_hit && !ds2_hit) |-> !do_wr) // R10
		else $error("dual filter miss accepted");
	AST_MASK_ALL: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(cand_valid && !full && cur_mask == CAF_MASK_RESET &&
		cur_mode == CAF_SINGLE_STD && legacy_hit) |-> do_wr) // R14 R15
		else $error("all-ignore mask rejected frame");
	AST_RETRY: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(tx_end && !tx_ok && !cur_no_retry) |=>
		(tx_retry && !tx_abandon)) // R19
		else $error("failed transmit not retried");
	AST_ONE_SHOT: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(tx_end && !tx_ok && cur_no_retry) |=>
		(tx_abandon && !tx_retry)) // R20
		else $error("single shot transmit retried");

	COV_ECHO_STORED: cover property (@(posedge ref_clk)
		disable iff (!arst_n) cand_echo && do_wr);
	COV_DUAL_SECOND: cover property (@(posedge ref_clk)
		disable iff (!arst_n) cur_mode == CAF_DUAL_EXT && c_ext &&
		!de1_hit && de2_hit && do_wr);
	COV_OVERFLOW: cover property (@(posedge ref_clk)
		disable iff (!arst_n) $rose(rx_overflow));
	COV_NOTIFY: cover property (@(posedge ref_clk)
		disable iff (!arst_n) $rose(multi_avail));

endmodule : caf_filter

// ### verilog/caf_pkg.sv
package caf_pkg;

	typedef enum logic [1:0] {
		CAF_SINGLE_STD,
		CAF_SINGLE_EXT,
		CAF_DUAL_STD,
		CAF_DUAL_EXT
	} caf_mode_t;

	localparam int unsigned CAF_ID_W = 29;
	localparam int unsigned CAF_SID_W = 11;
	localparam int unsigned CAF_CNT_W = 8;
	localparam int unsigned CAF_MAX_DEPTH = 128;

	// Reset values
	localparam caf_mode_t CAF_MODE_RESET = CAF_SINGLE_STD;
	localparam logic [31:0] CAF_COMPARE_RESET = 32'h0000_0000;
	localparam logic [31:0] CAF_MASK_RESET = 32'h0FFF_FFFF;
	localparam logic [7:0] CAF_DEPTH_RESET = 8'h64;
	localparam logic [7:0] CAF_THRESH_RESET = 8'h00;
	localparam logic [10:0] CAF_LEG_SHORT_RESET = 11'h000;
	localparam logic [28:0] CAF_LEG_LONG_RESET = 29'h0000_0000;
	localparam logic CAF_ECHO_RESET = 1'b0;
	localparam logic CAF_NO_RETRY_RESET = 1'b0;

	// Single standard layout, bits 31..28 reserved
	localparam int unsigned CAF_SS_ID_LSB = 17;
	localparam int unsigned CAF_SS_RTR = 16;
	localparam int unsigned CAF_SS_D0_LSB = 8;
	localparam int unsigned CAF_SS_D1_LSB = 0;
	// Single extended layout, bits 31..30 reserved
	localparam int unsigned CAF_SE_ID_LSB = 1;
	localparam int unsigned CAF_SE_RTR = 0;
	// Dual standard layout
	localparam int unsigned CAF_DS1_ID_LSB = 21;
	localparam int unsigned CAF_DS1_RTR = 20;
	localparam int unsigned CAF_DS1_D0_LSB = 12;
	localparam int unsigned CAF_DS2_ID_LSB = 1;
	localparam int unsigned CAF_DS2_RTR = 0;
	// Dual extended layout: upper 16 identifier bits per filter
	localparam int unsigned CAF_DE1_LSB = 16;
	localparam int unsigned CAF_DE2_LSB = 0;
	localparam int unsigned CAF_DE_ID_LSB = 13;

endpackage : caf_pkg
